// ---- core/trc_defs.svh ----
// register offsets, field positions, reset values and counts of the reload/capture timer
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH

`define TRC_ADDR_W 3
`define TRC_DATA_W 8

`define TRC_ADDR_CTRL 3'h0
`define TRC_ADDR_CFG 3'h1
`define TRC_ADDR_COUNT_LOW 3'h2
`define TRC_ADDR_COUNT_HIGH 3'h3
`define TRC_ADDR_RC_LOW 3'h4
`define TRC_ADDR_RC_HIGH 3'h5
`define TRC_ADDR_IE 3'h6

`define TRC_CTRL_OVF 7
`define TRC_CTRL_EXT 6
`define TRC_CTRL_PS_HI 5
`define TRC_CTRL_PS_LO 4
`define TRC_CTRL_MODE_HI 3
`define TRC_CTRL_MODE_LO 2
`define TRC_CTRL_RUN 1
`define TRC_CTRL_EXEN 0
`define TRC_CFG_SEL_HI 1
`define TRC_CFG_SEL_LO 0
`define TRC_IE_BIT 0

`define TRC_RST_BYTE 8'h00
`define TRC_RST_WORD 16'h0000
`define TRC_COUNT_MAX 16'hFFFF
`define TRC_COUNT_ONE 16'h0001

`define TRC_PS_LIMIT_1 8'h00
`define TRC_PS_LIMIT_8 8'h07
`define TRC_PS_LIMIT_64 8'h3F
`define TRC_PS_LIMIT_256 8'hFF
`define TRC_PS_ONE 8'h01

`define TRC_BAUD_LAST 4'hF
`define TRC_BAUD_ONE 4'h1

`endif

// ---- core/trc_pkg.sv ----
// types of the reload/capture timer
package trc_pkg;
`include "trc_defs.svh"

    typedef enum logic [1:0] {
        trc_mode_reload,
        trc_mode_baud,
        trc_mode_cap_rise,
        trc_mode_cap_fall
    } trc_mode_t;

    typedef enum logic [1:0] {
        trc_src_event_pin,
        trc_src_lfo,
        trc_src_uart_one_rx,
        trc_src_uart_two_rx
    } trc_src_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [2:0] armed;
    } trc_sync_state_t;

    typedef struct packed {
        logic [7:0] presc;
        logic [15:0] count;
        logic [15:0] reload;
        logic overflow_flag;
        logic external_event_flag;
        logic run_enable;
        logic external_event_enable;
        trc_mode_t mode_select;
        logic [1:0] prescale_select;
        trc_src_t capture_source_select;
        logic timer_interrupt_enable;
        logic [7:0] write_high_buf;
        logic [7:0] read_low_buf;
        logic [3:0] baud_div;
        logic baud_tick;
        logic irq;
        logic [7:0] rdata;
    } trc_state_t;
endpackage : trc_pkg

// ---- core/trc_edge_sync.sv ----
// two-stage synchroniser with rising and falling edge detection
`timescale 1ns/100ps
module trc_edge_sync
    import trc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // asynchronous level in
    input wire logic din,
    // edge pulses from the synchronised level
    output logic rise,
    output logic fall
);
    trc_sync_state_t st;
    trc_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.sync1 = din;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        next_st.armed = {st.armed[1:0], 1'b1};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // sync1 is seen only by sync2, edges come from the settled stages
    // edges wait until prev holds a real sample, so a pin idling high fakes no edge after reset
    assign rise = st.armed[2] & st.sync2 & ~st.prev;
    assign fall = st.armed[2] & ~st.sync2 & st.prev;
endmodule : trc_edge_sync

// ---- core/trc_timer.sv ----
// 16-bit reload/capture timer with prescaler, baud generation and edge events
// Functional notes
// - mode 0, events off: count up, on wrap set overflow flag and reload
// - mode 0, events on: overflow or event pin edge reloads; edge sets event flag
// - interrupt request raised when enabled and either flag is set
// - setting run enable starts counting from the present count, no clear
// - mode 01 is the second UART baud generator, reloads on every overflow
// - in baud mode an overflow raises no interrupt
// - in baud mode an event edge only sets the event flag, no reload
// - baud rate is prescaled clock / 16 / (65536 - reload value)
// - capture modes count freely, overflow sets flag and wraps to zero
// - mode 2: rising edge of selected input captures count, sets event flag
// - mode 3: falling edge of selected input captures count, sets event flag
// - mode codes: 00 reload, 01 baud, 10 rising capture, 11 falling capture
// - prescale codes 00..11 divide by 1, 8, 64, 256
// - capture source: event pin, low-frequency oscillator, UART1 rx, UART2 rx
// - hardware only sets the flags; software writes zero to clear them
`timescale 1ns/100ps
module trc_timer
    import trc_pkg::*;
#(
    parameter int ADDR_W = `TRC_ADDR_W,
    parameter int DATA_W = `TRC_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // event and capture sources
    input wire logic event_input_pin,
    input wire logic lfo_clock,
    input wire logic uart_one_receive_pin,
    input wire logic uart_two_receive_pin,
    // outputs to the system
    output logic irq,
    output logic uart_two_baud_tick
);
    trc_state_t st;
    trc_state_t next_st;

    logic [3:0] src_rise;
    logic [3:0] src_fall;
    logic [3:0] src_level;

    assign src_level = {uart_two_receive_pin, uart_one_receive_pin, lfo_clock, event_input_pin};

    // every source is synchronised on its own so switching the selector never fakes an edge
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_src
            trc_edge_sync u_sync (
                .clk(clk),
                .rstn(rstn),
                .din(src_level[gi]),
                .rise(src_rise[gi]),
                .fall(src_fall[gi])
            );
        end
    endgenerate

    logic [7:0] ps_limit;
    logic tick;
    logic wrap;
    logic pin_edge;
    logic sel_rise;
    logic sel_fall;
    logic cap_edge;
    logic ovf_set;
    logic ext_set;
    logic [15:0] count_inc;

    always_comb begin
        case (st.prescale_select)
            2'b00: ps_limit = `TRC_PS_LIMIT_1;
            2'b01: ps_limit = `TRC_PS_LIMIT_8;
            2'b10: ps_limit = `TRC_PS_LIMIT_64;
            default: ps_limit = `TRC_PS_LIMIT_256;
        endcase
    end

    always_comb begin
        sel_rise = src_rise[0];
        sel_fall = src_fall[0];
        case (st.capture_source_select)
            trc_src_event_pin: begin
                sel_rise = src_rise[0];
                sel_fall = src_fall[0];
            end
            trc_src_lfo: begin
                sel_rise = src_rise[1];
                sel_fall = src_fall[1];
            end
            trc_src_uart_one_rx: begin
                sel_rise = src_rise[2];
                sel_fall = src_fall[2];
            end
            default: begin
                sel_rise = src_rise[3];
                sel_fall = src_fall[3];
            end
        endcase
    end

    // prescaled count tick; >= so a smaller ratio picked mid-count cannot strand the divider
    assign tick = st.run_enable && (st.presc >= ps_limit);
    assign wrap = tick && (st.count == `TRC_COUNT_MAX);
    assign count_inc = st.count + `TRC_COUNT_ONE;
    assign pin_edge = src_rise[0] | src_fall[0];
    assign cap_edge = (st.mode_select == trc_mode_cap_rise) ? sel_rise : sel_fall;

    always_comb begin
        next_st = st;
        ovf_set = 1'b0;
        ext_set = 1'b0;
        next_st.rdata = `TRC_RST_BYTE;
        next_st.baud_tick = 1'b0;

        // prescaler
        if (!st.run_enable) begin
            next_st.presc = `TRC_RST_BYTE;
        end else if (tick) begin
            next_st.presc = `TRC_RST_BYTE;
        end else begin
            next_st.presc = st.presc + `TRC_PS_ONE;
        end

        // counting step; the count is never cleared by run enable
        if (tick) begin
            case (st.mode_select)
                trc_mode_reload: begin
                    if (wrap) begin
                        next_st.count = st.reload;
                        ovf_set = 1'b1;
                    end else begin
                        next_st.count = count_inc;
                    end
                end
                trc_mode_baud: begin
                    if (wrap) begin
                        next_st.count = st.reload;
                        // sixteen overflows make one baud period
                        next_st.baud_div = st.baud_div + `TRC_BAUD_ONE;
                        next_st.baud_tick = (st.baud_div == `TRC_BAUD_LAST);
                    end else begin
                        next_st.count = count_inc;
                    end
                end
                default: begin
                    next_st.count = count_inc;
                    ovf_set = wrap;
                end
            endcase
        end

        // software writes; clearing a flag takes a written zero
        if (wr) begin
            if (addr == `TRC_ADDR_CTRL) begin
                next_st.overflow_flag = wdata[`TRC_CTRL_OVF];
                next_st.external_event_flag = wdata[`TRC_CTRL_EXT];
                next_st.prescale_select = wdata[`TRC_CTRL_PS_HI:`TRC_CTRL_PS_LO];
                next_st.mode_select = trc_mode_t'(wdata[`TRC_CTRL_MODE_HI:`TRC_CTRL_MODE_LO]);
                next_st.run_enable = wdata[`TRC_CTRL_RUN];
                next_st.external_event_enable = wdata[`TRC_CTRL_EXEN];
            end else if (addr == `TRC_ADDR_CFG) begin
                next_st.capture_source_select = trc_src_t'(wdata[`TRC_CFG_SEL_HI:`TRC_CFG_SEL_LO]);
            end else if (addr == `TRC_ADDR_COUNT_HIGH) begin
                next_st.write_high_buf = wdata;
            end else if (addr == `TRC_ADDR_COUNT_LOW) begin
                // high byte first, the low write commits the whole word
                next_st.count = {st.write_high_buf, wdata};
            end else if (addr == `TRC_ADDR_RC_HIGH) begin
                next_st.write_high_buf = wdata;
            end else if (addr == `TRC_ADDR_RC_LOW) begin
                next_st.reload = {st.write_high_buf, wdata};
            end else if (addr == `TRC_ADDR_IE) begin
                next_st.timer_interrupt_enable = wdata[`TRC_IE_BIT];
            end
        end

        // edge events act after writes, so hardware wins a same-cycle collision
        if (st.external_event_enable) begin
            case (st.mode_select)
                trc_mode_reload: begin
                    if (pin_edge) begin
                        next_st.count = st.reload;
                        ext_set = 1'b1;
                    end
                end
                trc_mode_baud: begin
                    ext_set = pin_edge;
                end
                default: begin
                    if (cap_edge) begin
                        next_st.reload = st.count;
                        ext_set = 1'b1;
                    end
                end
            endcase
        end

        // a set in the clearing cycle is kept
        if (ovf_set) begin
            next_st.overflow_flag = 1'b1;
        end
        if (ext_set) begin
            next_st.external_event_flag = 1'b1;
        end

        // reads: data stands in the next cycle only
        if (rd) begin
            if (addr == `TRC_ADDR_CTRL) begin
                next_st.rdata = {st.overflow_flag, st.external_event_flag, st.prescale_select,
                                 st.mode_select, st.run_enable, st.external_event_enable};
            end else if (addr == `TRC_ADDR_CFG) begin
                next_st.rdata = {6'h00, st.capture_source_select};
            end else if (addr == `TRC_ADDR_COUNT_HIGH) begin
                // a running count is torn by two byte reads, so the low half is frozen here
                next_st.rdata = st.count[15:8];
                next_st.read_low_buf = st.count[7:0];
            end else if (addr == `TRC_ADDR_COUNT_LOW) begin
                next_st.rdata = st.read_low_buf;
            end else if (addr == `TRC_ADDR_RC_HIGH) begin
                next_st.rdata = st.reload[15:8];
            end else if (addr == `TRC_ADDR_RC_LOW) begin
                next_st.rdata = st.reload[7:0];
            end else if (addr == `TRC_ADDR_IE) begin
                next_st.rdata = {7'h00, st.timer_interrupt_enable};
            end else begin
                next_st.rdata = `TRC_RST_BYTE;
            end
        end

        next_st.irq = next_st.timer_interrupt_enable &&
                      (next_st.overflow_flag || next_st.external_event_flag);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign irq = st.irq;
    assign uart_two_baud_tick = st.baud_tick;
endmodule : trc_timer

// ---- testbench/trc_timer_chk.sv ----
// port-level assertions of the reload/capture timer
`timescale 1ns/100ps
module trc_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // outputs
    input wire logic irq,
    input wire logic uart_two_baud_tick
);
    // shadows of written fields; flag bits are not trusted, hardware sets them
    logic [7:0] ctl;
    logic [1:0] sel;
    logic ie;
    wire logic bq = ctl[7:6] == 2'h0 && ctl[3:2] == 2'h1 && !ctl[0];
    wire logic nb = ctl[3:2] != 2'h1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl <= 8'h00;
            sel <= 2'h0;
            ie <= 1'b0;
        end else if (wr) begin
            case (addr)
                3'h0: ctl <= wdata;
                3'h1: sel <= wdata[1:0];
                3'h6: ie <= wdata[0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_rd(logic [2:0] a);
        rd && addr == a;
    endsequence
    property p_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    property p_unmap;
        s_rd(3'h7) |=> rdata == 8'h00;
    endproperty
    property p_ctl;
        s_rd(3'h0) |=> rdata[5:0] == $past(ctl[5:0]);
    endproperty
    property p_cfg;
        s_rd(3'h1) |=> rdata == {6'h00, $past(sel)};
    endproperty
    property p_ie;
        s_rd(3'h6) |=> rdata == {7'h00, $past(ie)};
    endproperty
    // three samples cover the write-to-register and register-to-irq lag
    property p_ieoff;
        !ie && !$past(ie) && !$past(ie, 2) |-> !irq;
    endproperty
    property p_baud;
        bq && $past(bq) && $past(bq, 2) |-> !irq;
    endproperty
    property p_notick;
        nb && $past(nb) && $past(nb, 2) |-> !uart_two_baud_tick;
    endproperty
    property p_gap;
        uart_two_baud_tick |=> (!uart_two_baud_tick) [*8];
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_ctl: assert property (p_ctl) else $error("control readback wrong");
    a_cfg: assert property (p_cfg) else $error("source select readback wrong");
    a_ie: assert property (p_ie) else $error("enable readback wrong");
    a_ieoff: assert property (p_ieoff) else $error("irq while disabled");
    a_baud: assert property (p_baud) else $error("irq from baud overflow");
    a_notick: assert property (p_notick) else $error("tick outside baud mode");
    a_gap: assert property (p_gap) else $error("baud ticks too close");
endmodule : trc_chk

// ---- testbench/tb_top.sv ----
// self-checking bench of the reload/capture timer
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] src = 4'h0;
    logic [7:0] rdata;
    logic irq;
    logic tick;
    logic [15:0] v;
    logic [15:0] r;
    logic [15:0] c;
    logic [7:0] b;
    int n;
    int p;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'hc8355ee8;
    trc_timer trc_timer_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .event_input_pin(src[0]), .lfo_clock(src[1]), .uart_one_receive_pin(src[2]),
        .uart_two_receive_pin(src[3]), .irq(irq), .uart_two_baud_tick(tick));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checks_done++;
        if (^got === 1'bx || got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : chk_in
    function automatic int per(int k);
        return k == 0 ? 1 : (k == 1 ? 8 : (k == 2 ? 64 : 256));
    endfunction : per
    task automatic wr8(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr8
    task automatic rd8(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd8
    // high byte first: the low write commits the pair, the count high read latches the low half
    task automatic wr16(input logic [2:0] a, input logic [15:0] d);
        wr8(a + 3'h1, d[15:8]);
        wr8(a, d[7:0]);
    endtask : wr16
    task automatic rd16(input logic [2:0] a, output logic [15:0] d);
        rd8(a + 3'h1, d[15:8]);
        rd8(a, d[7:0]);
    endtask : rd16
    task automatic drive(input int i, input logic lv);
        @(posedge clk);
        src[i] <= lv;
        repeat (5) @(posedge clk);
    endtask : drive
    // cycles until irq (w=0) or tick (w=1), always at least one
    task automatic wait_for(input int w, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((w ? tick : irq) !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            miscompares++;
            end_sim();
        end
    endtask : wait_for
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd8(a[2:0], b);
            chk(b, 16'h0000);
        end
        wr8(3'h6, 8'h01);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed) & 16'h7FFF;
            wr8(3'h0, 8'h00);
            wr16(3'h2, 16'hFFFE);
            wr16(3'h4, r);
            wr8(3'h0, {2'h0, k[1:0], 4'h2});
            wait_for(0, n);
            chk(n, 2 * per(k));
            rd8(3'h0, b);
            chk(b, {2'h2, k[1:0], 4'h2});
            wr8(3'h0, 8'h00);
            rd16(3'h2, v);
            chk(v, r + (k == 0 ? 16'h0004 : 16'h0000));
            chk(irq, 16'h0000);
        end
        r = $random(seed);
        wr16(3'h4, r);
        for (int e = 0; e < 2; e++) begin
            c = $random(seed);
            wr16(3'h2, c);
            wr8(3'h0, 8'h01);
            drive(0, e == 0);
            rd16(3'h2, v);
            chk(v, r);
            chk(irq, 16'h0001);
            rd8(3'h0, b);
            chk(b, 16'h0041);
        end
        for (int m = 2; m < 4; m++) begin
            for (int s = 0; s < 4; s++) begin
                c = $random(seed);
                wr8(3'h0, 8'h00);
                drive(s, m == 2);
                wr8(3'h1, s[7:0]);
                wr16(3'h2, c);
                wr16(3'h4, ~c);
                wr8(3'h0, {4'h0, m[1:0], 2'h1});
                // both edges of an unselected source must not capture
                drive((s + 1) % 4, ~src[(s + 1) % 4]);
                drive((s + 1) % 4, ~src[(s + 1) % 4]);
                drive(s, m != 2);
                rd16(3'h4, v);
                chk(v, ~c);
                drive(s, m == 2);
                rd16(3'h4, v);
                chk(v, c);
                rd8(3'h0, b);
                chk(b, {4'h4, m[1:0], 2'h1});
            end
        end
        // capture mode runs free: the wrap gives zero, never the reload value
        wr8(3'h0, 8'h00);
        wr16(3'h4, 16'h8000);
        wr16(3'h2, 16'hFFFE);
        wr8(3'h0, 8'h0A);
        wait_for(0, n);
        chk(n, 16'h0002);
        wr8(3'h0, 8'h00);
        rd16(3'h2, v);
        chk(v, 16'h0002);
        r = 16'hFFF0 | 16'($random(seed) & 15);
        p = $random(seed) & 1;
        wr8(3'h0, 8'h00);
        wr16(3'h4, r);
        wr16(3'h2, r);
        wr8(3'h0, {2'h0, p[1:0], 4'h6});
        wait_for(1, n);
        wait_for(1, n);
        chk(n, 16 * (65536 - r) * per(p));
        chk(irq, 16'h0000);
        wr8(3'h0, 8'h05);
        c = $random(seed);
        wr16(3'h2, c);
        drive(0, ~src[0]);
        rd16(3'h2, v);
        chk(v, c);
        chk(irq, 16'h0001);
        rd8(3'h0, b);
        chk(b, 16'h0045);
        end_sim();
    end
endmodule : tb_top
bind trc_timer trc_chk trc_chk_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .uart_two_baud_tick(uart_two_baud_tick));
